// file: src/adcsp_core.sv
`timescale 1ns/100ps
// Functional notes
// - Reset loads configuration defaults and idles powered down with the port alive.
// - Mode bit one keeps the converter idle until a one-shot trigger.
// - Trigger wakes within 25 us, clears itself, converts once, powers down.
// - Trigger written during a running conversion is ignored, never queued.
// - Mode bit zero converts back to back, storing every result.
// - Conversion in progress finishes on old settings; new ones apply next.
// - Writing mode one or reset returns to single-shot operation.
// - Chip select high resets the port, ignores clock, releases the pin.
// - On chip select low the pin shows low for new data, else high.
// - Transfer start copies the result into the shifter and holds it.
// - Serial clock low for 28 ms resets the port.
// - Data in is sampled on falling clock edges and never driven.
// - Output bits change on rising edges, bit 15 first.
// - The pin goes low when a new result becomes available.
// - Unread in continuous mode, the pin rises 8 us before next ready.
// - Chip select high pulls the pin up unless the pull-up bit is cleared.
// - Results are two's complement, saturating at 7fff and 8000.
// - Latest result is held until overwritten, so reads are never torn.
// - 32-bit transfers send the result then echo the configuration written.
// - Next transfer sends the buffered result, new or repeated.
// - Configuration is taken only when its key field equals 01.
module adcsp_core
#(
  parameter int unsigned TIMEOUT_CYCLES = adcsp_pkg::TIMEOUT_CYC,
  parameter int unsigned CONV_CYCLES = adcsp_pkg::CONV_US_DEFAULT * (adcsp_pkg::CLK_HZ / 1_000_000)
)
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic serial_in,
  input wire logic signed [17:0] sample_in,
  output logic data_ready_out,
  output logic data_ready_oe_out,
  output logic pullup_en_out,
  output logic [adcsp_pkg::CFG_W-1:0] config_out,
  output logic [adcsp_pkg::RES_W-1:0] result_out,
  output logic converting_out
);
  import adcsp_pkg::*;

  // Synchroniser stages; only the second stage feeds any logic.
  logic cs_meta;
  logic cs_sync;
  logic sclk_meta;
  logic sclk_sync;
  // Delayed copy of the synchronised clock, used to find its edges.
  logic sclk_prev;
  logic din_meta;
  logic din_sync;
  // Edge strobes of the serial clock, valid only while selected.
  logic sclk_rise;
  logic sclk_fall;
  logic [CFG_W-1:0] cfg;
  logic [CFG_W-1:0] conv_cfg;
  logic [CFG_W-1:0] shift_in;
  logic [RES_W-1:0] result;
  logic [31:0] shift_out;
  logic [5:0] bit_cnt;
  logic in_xfer;
  logic new_data;
  logic trigger;
  logic [31:0] timer;
  logic [31:0] idle_cnt;
  logic port_reset;
  logic cfg_load;
  logic conv_done;
  logic lead_window;
  adcsp_state_e state;

  // Saturates a wide sample to the signed 16-bit result range.
  function automatic logic [RES_W-1:0] saturate(input logic signed [17:0] v);
    logic [RES_W-1:0] r;
    r = v[RES_W-1:0];
    if (v > 18'sd32767)
    begin
      r = RES_POS_FS;
    end
    else if (v < -18'sd32768)
    begin
      r = RES_NEG_FS;
    end
    return r;
  endfunction : saturate

  // Turns a received word into the stored configuration value.
  // The trigger bit never stores and the fixed bits always read back set,
  // so the echo and the register always agree.
  function automatic logic [CFG_W-1:0] cfg_word(input logic [CFG_W-1:0] w);
    logic [CFG_W-1:0] r;
    r = (w & CFG_WMASK) | CFG_FIXED1;
    return r;
  endfunction : cfg_word

  // Two-flop synchronisers for pins from outside the clock domain.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      din_meta <= 1'b0;
      din_sync <= 1'b0;
    end
    else
    begin
      cs_meta <= cs_n_in;
      cs_sync <= cs_meta;
      sclk_meta <= sclk_in;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      din_meta <= serial_in;
      din_sync <= din_meta;
    end
  end

  // Edge detection on the synchronised clock.
  // Both strobes are masked by chip select, so a clock that toggles while
  // the port is deselected never moves the shifter.
  // The previous-value flop resets low, the idle level of the clock pin,
  // so no false rising edge follows reset.
  assign sclk_rise = sclk_sync & ~sclk_prev & ~cs_sync;
  assign sclk_fall = ~sclk_sync & sclk_prev & ~cs_sync;

  // Serial clock low-time watchdog.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      idle_cnt <= '0;
    end
    else if (sclk_sync || cs_sync || !in_xfer)
    begin
      idle_cnt <= '0;
    end
    else if (idle_cnt < TIMEOUT_CYCLES)
    begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // Port resets on chip select high or clock-low timeout.
  assign port_reset = cs_sync || (idle_cnt >= TIMEOUT_CYCLES);

  // A received word updates configuration only with the valid key.
  // The word completes on the sixteenth falling edge; its key bits then sit
  // one place lower in the shifter, the last bit still arriving on din_sync.
  assign cfg_load = sclk_fall && in_xfer && (bit_cnt == BITS_HALF - 6'h1)
                    && (shift_in[CFG_KEY_LSB-1 +: 2] == CFG_KEY_VALID);

  // Serial shifter: snapshot, output on rise, sample on fall.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      in_xfer <= 1'b0;
      bit_cnt <= '0;
      shift_out <= '0;
      shift_in <= '0;
      data_ready_out <= 1'b1;
    end
    else if (port_reset)
    begin
      in_xfer <= 1'b0;
      bit_cnt <= '0;
      data_ready_out <= ~new_data;
    end
    else
    begin
      if (sclk_rise)
      begin
        if (!in_xfer)
        begin
          in_xfer <= 1'b1;
          shift_out <= {result, cfg[CFG_W-1:1], 1'b1} << 1;
          data_ready_out <= result[RES_W-1];
        end
        else
        begin
          shift_out <= shift_out << 1;
          data_ready_out <= shift_out[31];
        end
      end
      else if (!in_xfer)
      begin
        data_ready_out <= ~new_data;
      end
      if (sclk_fall && in_xfer)
      begin
        shift_in <= {shift_in[CFG_W-2:0], din_sync};
        bit_cnt <= bit_cnt + 6'h1;
      end
      // The sixteenth falling edge swaps the echo half for the word just taken,
      // so the last sixteen bits read back the stored form of the word written in the first, trigger bit cleared.
      // Rising and falling strobes never share a cycle, so no shift is lost.
      if (cfg_load)
      begin
        shift_out[31 -: CFG_W] <= cfg_word({shift_in[CFG_W-2:0], din_sync});
      end
    end
  end

  // Configuration register; trigger bit self-clears on wake-up.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      cfg <= CFG_RESET;
      trigger <= 1'b0;
    end
    else
    begin
      // A keyed word stores at once; the converter picks it up at its next start.
      if (cfg_load)
      begin
        cfg <= cfg_word({shift_in[CFG_W-2:0], din_sync});
        if (shift_in[CFG_W-2] && state == ADCSP_IDLE)
        begin
          trigger <= 1'b1;
        end
      end
      else if (state == ADCSP_WAKE)
      begin
        trigger <= 1'b0;
      end
    end
  end

  // Sequencer: idle, wake-up delay, conversion.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state <= ADCSP_IDLE;
      timer <= '0;
      conv_cfg <= CFG_RESET;
    end
    else
    begin
      case (state)
        ADCSP_IDLE:
        begin
          timer <= '0;
          if (trigger || !cfg[CFG_MODE_BIT])
          begin
            state <= ADCSP_WAKE;
          end
        end
        ADCSP_WAKE:
        begin
          timer <= timer + 32'h1;
          if (timer >= POWERUP_CYC - 1)
          begin
            timer <= '0;
            conv_cfg <= cfg;
            state <= ADCSP_CONV;
          end
        end
        ADCSP_CONV:
        begin
          timer <= timer + 32'h1;
          if (conv_done)
          begin
            timer <= '0;
            conv_cfg <= cfg;
            state <= cfg[CFG_MODE_BIT] ? ADCSP_IDLE : ADCSP_CONV;
          end
        end
        default:
        begin
          state <= ADCSP_IDLE;
          timer <= '0;
        end
      endcase
    end
  end

  assign conv_done = (state == ADCSP_CONV) && (timer >= CONV_CYCLES - 1);
  assign lead_window = (state == ADCSP_CONV) && !conv_cfg[CFG_MODE_BIT]
                       && (timer >= CONV_CYCLES - 1 - READY_LEAD_CYC);

  // Result buffer and new-data flag; a finish beats a read that clears it.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      result <= RES_RESET;
      new_data <= 1'b0;
    end
    else if (conv_done)
    begin
      result <= saturate(sample_in);
      new_data <= 1'b1;
    end
    else if ((sclk_rise && !in_xfer) || (lead_window && !in_xfer))
    begin
      new_data <= 1'b0;
    end
  end

  // Pin enable and status outputs.
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      data_ready_oe_out <= 1'b0;
      pullup_en_out <= 1'b1;
      config_out <= CFG_RESET;
      result_out <= RES_RESET;
      converting_out <= 1'b0;
    end
    else
    begin
      data_ready_oe_out <= ~cs_sync;
      pullup_en_out <= cs_sync & cfg[CFG_PULLUP_BIT];
      config_out <= cfg;
      result_out <= result;
      converting_out <= (state != ADCSP_IDLE);
    end
  end

endmodule : adcsp_core

// file: src/adcsp_pkg.sv
package adcsp_pkg;

  // Clock rate and documented times.
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned POWERUP_US = 25;
  localparam int unsigned READY_LEAD_US = 8;
  localparam int unsigned TIMEOUT_MS = 28;
  localparam int unsigned POWERUP_CYC = (POWERUP_US * (CLK_HZ / 1_000_000));
  localparam int unsigned READY_LEAD_CYC = (READY_LEAD_US * (CLK_HZ / 1_000_000));
  localparam int unsigned TIMEOUT_CYC = (TIMEOUT_MS * (CLK_HZ / 1_000));

  // Conversion time of the default data rate, in microseconds (1 / rate).
  localparam int unsigned CONV_US_DEFAULT = 10_000;

  // Configuration word layout.
  localparam int unsigned CFG_W = 16;
  localparam int unsigned RES_W = 16;
  localparam int unsigned CFG_OS_BIT = 15;
  localparam int unsigned CFG_MUX_LSB = 12;
  localparam int unsigned CFG_PGA_LSB = 9;
  localparam int unsigned CFG_MODE_BIT = 8;
  localparam int unsigned CFG_DR_LSB = 5;
  localparam int unsigned CFG_PULLUP_BIT = 3;
  localparam int unsigned CFG_KEY_LSB = 1;
  localparam int unsigned CFG_RSV0_BIT = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h058b;
  localparam logic [CFG_W-1:0] CFG_WMASK = 16'h7fe8;
  // Bit 0 always reads one; a stored word always carries the valid key 01.
  localparam logic [CFG_W-1:0] CFG_FIXED1 = 16'h0003;
  localparam logic [1:0] CFG_KEY_VALID = 2'h1;

  // Result saturation codes.
  localparam logic [RES_W-1:0] RES_POS_FS = 16'h7fff;
  localparam logic [RES_W-1:0] RES_NEG_FS = 16'h8000;
  localparam logic [RES_W-1:0] RES_RESET = 16'h0000;

  // Bit counts of a transfer.
  localparam logic [5:0] BITS_HALF = 6'h10;
  localparam logic [5:0] BITS_FULL = 6'h20;

  // Converter sequencing states.
  typedef enum logic [2:0]
  {
    ADCSP_IDLE = 3'b001,
    ADCSP_WAKE = 3'b010,
    ADCSP_CONV = 3'b100
  } adcsp_state_e;

endpackage : adcsp_pkg

// file: testbench/adcsp_host.sv
`timescale 1ns/100ps
// Mode 1 host: clock idles low, data changes on rise and is read on fall.
module adcsp_host
(
  input wire logic miso_in,
  output logic cs_n_out = 1'b1,
  output logic sclk_out = 1'b0,
  output logic sdi_out = 1'b0
);
  // One frame of n bits, msb first; rdy is the pin level just after select.
  task automatic xfer(input logic [31:0] din, input int n, output logic rdy,
                      output logic [31:0] dout);
    dout = '0;
    #8 cs_n_out = 1'b0;
    #80 rdy = miso_in;
    for (int i = 31; i > 31 - n; i--)
    begin
      sclk_out = 1'b1;
      sdi_out = din[i];
      #40 sclk_out = 1'b0;
      dout = {dout[30:0], miso_in};
      #40;
    end
    cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #80;
  endtask : xfer
  // A lone clock pulse that leaves the frame hanging.
  task automatic stray();
    #8 cs_n_out = 1'b0;
    #80 sclk_out = 1'b1;
    #40 sclk_out = 1'b0;
  endtask : stray
endmodule : adcsp_host

// file: testbench/adcsp_chk.sv
`timescale 1ns/100ps
// Port checks of the conversion control and serial port.
module adcsp_chk
(
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic cs_n_in,
  input wire logic data_ready_out,
  input wire logic data_ready_oe_out,
  input wire logic pullup_en_out,
  input wire logic [adcsp_pkg::CFG_W-1:0] config_out,
  input wire logic [adcsp_pkg::RES_W-1:0] result_out,
  input wire logic converting_out
);
  import adcsp_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Pin drive and pull-up follow chip select.
  oe_release_a: assert property (cs_n_in [*5] |-> !data_ready_oe_out)
    else $error("Pin driven while deselected.");
  oe_drive_a: assert property (!cs_n_in [*5] |-> data_ready_oe_out)
    else $error("Pin idle while selected.");
  pull_cfg_a: assert property (cs_n_in [*5] |-> pullup_en_out == config_out[3])
    else $error("Pull-up differs from its bit.");
  pull_off_a: assert property (!cs_n_in [*5] |-> !pullup_en_out)
    else $error("Pull-up on while selected.");
  // Configuration and converter sequencing.
  fixed_bits_a: assert property (config_out[0] && !config_out[15])
    else $error("Fixed config bits wrong.");
  result_hold_a: assert property ($changed(result_out) |-> $past(converting_out))
    else $error("Result changed without conversion.");
  conv_stop_a: assert property ($fell(converting_out) |-> config_out[8])
    else $error("Stopped in continuous mode.");
  idle_stay_a: assert property (cs_n_in [*5] ##0 (config_out[8] && !converting_out)
    |=> !converting_out)
    else $error("Conversion started untriggered.");
  conv_run_a: assert property ($rose(converting_out) |-> converting_out [*8])
    else $error("Conversion cut short.");
  cover property ($fell(converting_out));
  cover property ($changed(result_out));
  cover property ($fell(data_ready_out) && data_ready_oe_out);
endmodule : adcsp_chk
bind adcsp_core adcsp_chk chk (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .cs_n_in(cs_n_in), .data_ready_out(data_ready_out), .data_ready_oe_out(data_ready_oe_out),
  .pullup_en_out(pullup_en_out), .config_out(config_out), .result_out(result_out),
  .converting_out(converting_out));

// file: testbench/tb_adc_conversion_control_serial_port.sv
`timescale 1ns/100ps
// Bench: one-shot rows first, then the awkward cases.
module tb_adc_conversion_control_serial_port;
  import adcsp_pkg::*;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic signed [17:0] sample_in = '0;
  logic cs_n, sclk, sdi, dr, oe, pu, cv, rdy;
  logic [15:0] cfg, res;
  logic [31:0] dout;
  logic [33:0] rows [7] = '{{18'h1ffff, 16'h7fff}, {18'h07fff, 16'h7fff},
    {18'h00001, 16'h0001}, {18'h0, 16'h0}, {18'h3ffff, 16'hffff},
    {18'h38000, 16'h8000}, {18'h20000, 16'h8000}};
  logic [15:0] keys [2] = '{16'hffff, 16'h0489};
  int bad_count = 0;
  int compares = 0;
  int n;
  adcsp_host host (.miso_in(oe ? dr : (pu ? 1'b1 : ~dr)), .cs_n_out(cs_n),
    .sclk_out(sclk), .sdi_out(sdi));
  adcsp_core #(.TIMEOUT_CYCLES(500), .CONV_CYCLES(2000)) uut (.ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in), .cs_n_in(cs_n), .sclk_in(sclk), .serial_in(sdi),
    .sample_in(sample_in), .data_ready_out(dr), .data_ready_oe_out(oe),
    .pullup_en_out(pu), .config_out(cfg), .result_out(res), .converting_out(cv));
  // Clock at 125 MHz.
  initial
  begin
    forever #4 ref_clk_in = ~ref_clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  // Waits out a running conversion and counts its cycles.
  task automatic run_one();
    n = 0;
    while (cv === 1'b1 && n < 8000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
  endtask : run_one
  task automatic set_sample(input logic [17:0] v);
    @(negedge ref_clk_in);
    sample_in = v;
  endtask : set_sample
  // Main sequence.
  initial
  begin
    repeat (10) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    check(cfg, 16'h058b);
    check({res, cv, pu, oe}, 19'h2);
    $display("done reset");
    foreach (rows[i])
    begin
      set_sample(rows[i][33:16]);
      host.xfer({2{16'h858b}}, 32, rdy, dout);
      check(dout[15:0], 16'h058b);
      check(cv, 1'b1);
      run_one();
      check(n > 1900 && n < POWERUP_CYC + 2000, 1'b1);
      check({cfg, res}, {16'h058b, rows[i][15:0]});
      host.xfer('0, 16, rdy, dout);
      check({rdy, dout[15:0]}, {1'b0, rows[i][15:0]});
      $display("done row %0d", i);
    end
    host.xfer('0, 16, rdy, dout);
    check({rdy, dout[15:0]}, 17'h18000);
    set_sample(18'h00123);
    host.xfer({2{16'h858b}}, 32, rdy, dout);
    host.xfer({2{16'h858b}}, 32, rdy, dout);
    run_one();
    set_sample(18'h00456);
    repeat (6000) @(negedge ref_clk_in);
    check(res, 16'h0123);
    $display("done retrigger");
    host.stray();
    repeat (600) @(negedge ref_clk_in);
    host.xfer('0, 16, rdy, dout);
    check(dout[15:0], 16'h0123);
    $display("done timeout");
    foreach (keys[i])
    begin
      host.xfer({2{keys[i]}}, 32, rdy, dout);
      check({cfg, cv}, {16'h058b, 1'b0});
    end
    host.xfer({2{16'h0583}}, 32, rdy, dout);
    check({cfg, pu}, {16'h0583, 1'b0});
    $display("done keys");
    set_sample(18'h00777);
    host.xfer({2{16'h048b}}, 32, rdy, dout);
    repeat (7500) @(negedge ref_clk_in);
    check({res, cv, pu}, {16'h0777, 2'h3});
    sample_in = 18'h00888;
    repeat (2100) @(negedge ref_clk_in);
    check(res, 16'h0888);
    host.xfer({2{16'h058b}}, 32, rdy, dout);
    repeat (2100) @(negedge ref_clk_in);
    check(cv, 1'b0);
    $display("done continuous");
    summarize();
  end
  // Watchdog well past the expected run length.
  initial
  begin
    repeat (90000) @(posedge ref_clk_in);
    bad_count++;
    summarize();
  end
endmodule : tb_adc_conversion_control_serial_port
